// ---- pkg/bix_pkg.sv ----
package bix_pkg;

  localparam int WORD_W = 12;
  localparam int DATA_W = 8;
  localparam int FSEL_W = 5;
  localparam int PC_W = 9;
  localparam int NUM_FILES = 32;

  // Instruction word fields
  localparam int OPC_HI = 11;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 5;
  localparam int FSEL_HI = 4;
  localparam int FSEL_LO = 0;
  localparam int LIT_HI = 7;
  localparam int LIT_LO = 0;
  localparam int ROT_OP_LO = 6;

  // Encodings
  localparam logic [WORD_W-1:0] ENC_OPTION_LOAD = 12'h002;
  localparam logic [3:0] OPC_RETURN_LIT = 4'h8;
  localparam logic [5:0] OPC_ROTATE_LEFT = 6'h0d;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST = 8'hff;
  localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
  localparam logic [PC_W-1:0] PC_RST = 9'h1ff;
  localparam logic CARRY_RST = 1'b0;
  localparam logic [DATA_W-1:0] FILE_RST = 8'ha5;

  // Timing
  localparam int RETURN_CYCLES = 2;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] word;
  } bix_instr_t;

  typedef struct packed {
    logic we;
    logic [FSEL_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bix_fwrite_t;

  typedef enum logic [1:0] {
    BIX_EXEC = 2'b01,
    BIX_RET2 = 2'b10
  } bix_state_t;

endpackage

// ---- design/bix_exec.sv ----
// Functional notes
// RULE1: Option-load copies accumulator to option register; flags kept.
// RULE2: Return: literal to accumulator, PC from stack top, two cycles.
// RULE3: Rotate left through carry: old carry to bit 0, bit 7 to carry.
// RULE4: Destination 0 writes accumulator; 1 writes the file register back.
// RULE5: Five-bit file-select field addresses file registers 0 to 31.
// RULE6: Option-load is one fixed operand-free word, single cycle.
// RULE7: Twelve-bit word; destination at bit 5, file select in bits 4..0.
module bix_exec
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire bix_pkg::bix_instr_t i_instr,
  input wire logic [bix_pkg::PC_W-1:0] i_top_stack_entry,
  output logic o_instr_ready,
  output logic [bix_pkg::DATA_W-1:0] o_acc,
  output logic [bix_pkg::DATA_W-1:0] o_option,
  output logic o_carry,
  output logic [bix_pkg::PC_W-1:0] o_pc,
  output logic o_pc_load,
  output logic o_stack_pop,
  output bix_pkg::bix_fwrite_t o_fwrite
);
  import bix_pkg::*;

  logic [DATA_W-1:0] file_mem [NUM_FILES];
  logic [DATA_W-1:0] acc_reg, acc_next;
  logic [DATA_W-1:0] option_reg, option_next;
  logic carry_reg, carry_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic pc_load_reg, pc_load_next;
  logic pop_reg, pop_next;
  bix_fwrite_t fw_reg, fw_next;
  bix_state_t state_reg, state_next;

  logic is_option, is_return, is_rotate;
  logic [FSEL_W-1:0] fsel;
  logic dest;
  logic [DATA_W-1:0] src;
  logic [DATA_W:0] rot;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  assign is_option = i_instr.word == ENC_OPTION_LOAD; // RULE6
  assign is_return = i_instr.word[OPC_HI:OPC_LO] == OPC_RETURN_LIT;
  assign is_rotate = i_instr.word[OPC_HI:ROT_OP_LO] == OPC_ROTATE_LEFT;
  assign fsel = i_instr.word[FSEL_HI:FSEL_LO]; // RULE5 RULE7
  assign dest = i_instr.word[DEST_BIT]; // RULE7
  assign src = file_mem[fsel];
  assign rot = {src, carry_reg}; // RULE3

  // A return stalls fetch during its second cycle
  assign o_instr_ready = state_reg == BIX_EXEC;

  ////////////////////////////////////////////////////////////////////////////
  // Execute

  always_comb
  begin
    acc_next = acc_reg;
    option_next = option_reg;
    carry_next = carry_reg;
    pc_next = pc_reg;
    pc_load_next = 1'b0;
    pop_next = 1'b0;
    fw_next = '{we: 1'b0, addr: fsel, data: rot[DATA_W-1:0]};
    state_next = state_reg;
    unique case (state_reg)
      BIX_EXEC:
      begin
        if (i_instr.valid)
        begin
          if (is_option)
            option_next = acc_reg; // RULE1
          else if (is_return)
          begin
            acc_next = i_instr.word[LIT_HI:LIT_LO]; // RULE2
            pc_next = i_top_stack_entry; // RULE2
            pop_next = 1'b1;
            state_next = BIX_RET2;
          end
          else if (is_rotate)
          begin
            carry_next = rot[DATA_W]; // RULE3
            if (dest)
              fw_next.we = 1'b1; // RULE4
            else
              acc_next = rot[DATA_W-1:0]; // RULE4
          end
        end
      end
      BIX_RET2:
      begin
        // Second cycle is the flush; the o_pc_load pulse shows in the cycle after it
        pc_load_next = 1'b1; // RULE2
        state_next = BIX_EXEC;
      end
      default:
        state_next = BIX_EXEC;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      acc_reg <= ACC_RST;
      option_reg <= OPTION_RST;
      carry_reg <= CARRY_RST;
      pc_reg <= PC_RST;
      pc_load_reg <= 1'b0;
      pop_reg <= 1'b0;
      fw_reg <= '0;
      state_reg <= BIX_EXEC;
    end
    else if (i_ce)
    begin
      acc_reg <= acc_next;
      option_reg <= option_next;
      carry_reg <= carry_next;
      pc_reg <= pc_next;
      pc_load_reg <= pc_load_next;
      pop_reg <= pop_next;
      fw_reg <= fw_next;
      state_reg <= state_next;
    end
  end

  // File array resets to a known byte; an unknown entry would poison the
  // carry on the first rotate and from there every later result
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int k = 0; k < NUM_FILES; k++)
        file_mem[k] <= FILE_RST;
    end
    else if (i_ce && fw_next.we)
      file_mem[fw_next.addr] <= fw_next.data; // RULE4
  end

  assign o_acc = acc_reg;
  assign o_option = option_reg;
  assign o_carry = carry_reg;
  assign o_pc = pc_reg;
  assign o_pc_load = pc_load_reg;
  assign o_stack_pop = pop_reg;
  assign o_fwrite = fw_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [DATA_W-1:0] rot_acc_src;
  assign rot_acc_src = src;

  a_option_load: assert property ( // RULE1
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_instr_ready && i_instr.valid && is_option
    |=> o_option == $past(acc_reg) && o_carry == $past(carry_reg))
    else $error("option register not loaded from accumulator");

  // The dead cycle only advances when enabled, so look at the enable of it
  a_return_two: assert property ( // RULE2
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_instr_ready && i_instr.valid && is_return
    |=> !o_instr_ready && o_acc == $past(i_instr.word[LIT_HI:LIT_LO])
    ##1 (!$past(i_ce) || (o_pc_load && o_instr_ready)))
    else $error("literal return not two cycles");

  a_return_flags: assert property ( // RULE2
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_instr_ready && i_instr.valid && is_return
    |=> o_carry == $past(carry_reg))
    else $error("literal return changed carry");

  a_rotate_carry: assert property ( // RULE3
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_instr_ready && i_instr.valid && is_rotate
    |=> o_carry == $past(rot_acc_src[DATA_W-1]))
    else $error("rotate carry out wrong");

  a_rotate_acc: assert property ( // RULE4
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_instr_ready && i_instr.valid && is_rotate && !dest
    |=> o_acc == {$past(rot_acc_src[DATA_W-2:0]), $past(carry_reg)}
        && !o_fwrite.we)
    else $error("rotate to accumulator wrong");

  a_rotate_file: assert property ( // RULE5
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_instr_ready && i_instr.valid && is_rotate && dest
    |=> o_fwrite.we && o_fwrite.addr == $past(fsel)
        && o_acc == $past(acc_reg))
    else $error("rotate write-back wrong");

  a_option_once: assert property ( // RULE6
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_instr_ready && i_instr.valid && is_option |=> o_instr_ready)
    else $error("option-load not single cycle");

  a_return_pop: assert property ( // RULE2
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_instr_ready && i_instr.valid && is_return
    |=> o_stack_pop && o_pc == $past(i_top_stack_entry) && !o_pc_load)
    else $error("literal return did not pop the stack");

  // Whatever is offered during the dead cycle must leave no trace
  a_dead_cycle: assert property ( // RULE2
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && !o_instr_ready
    |=> o_instr_ready && $stable(o_acc) && $stable(o_option)
        && $stable(o_carry) && !o_fwrite.we)
    else $error("word taken during return dead cycle");

  // The array itself is checked, not only the write port
  a_rotate_data: assert property ( // RULE3
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_instr_ready && i_instr.valid && is_rotate && dest
    |=> o_fwrite.data == {$past(rot_acc_src[DATA_W-2:0]), $past(carry_reg)}
        && file_mem[$past(fsel)] == o_fwrite.data)
    else $error("rotate write-back data wrong");

  // Near misses of a fixed pattern must behave as no-ops
  a_refused_word: assert property ( // RULE6
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_instr_ready && i_instr.valid
    && !is_option && !is_return && !is_rotate
    |=> o_instr_ready && !o_fwrite.we && !o_stack_pop
        && $stable(o_acc) && $stable(o_option) && $stable(o_carry))
    else $error("unknown word changed state");

endmodule // bix_exec

// ---- sim/baseline_instr_exec_subset_test.sv ----
module baseline_instr_exec_subset_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bix_pkg::*;
  logic i_clk = 0;
  logic i_rst_n = 0;
  logic i_ce = 1;
  bix_instr_t i_instr = '0;
  logic [PC_W-1:0] i_top_stack_entry = '0;
  logic o_instr_ready, o_carry, o_pc_load, o_stack_pop;
  logic [DATA_W-1:0] o_acc, o_option;
  logic [PC_W-1:0] o_pc;
  bix_fwrite_t o_fwrite;
  int num_errors = 0;
  int n_checks = 0;
  logic [7:0] rs = 8'h1b;
  logic [7:0] acc, opt, v, r;
  logic [7:0] mem [NUM_FILES];
  logic [8:0] pc;
  logic [4:0] f, fa;
  logic [2:0] sel;
  logic [11:0] w;
  logic car, we;

  always #5 i_clk = ~i_clk;

  bix_exec bix_exec_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_instr(i_instr),
    .i_top_stack_entry(i_top_stack_entry),
    .o_instr_ready(o_instr_ready),
    .o_acc(o_acc),
    .o_option(o_option),
    .o_carry(o_carry),
    .o_pc(o_pc),
    .o_pc_load(o_pc_load),
    .o_stack_pop(o_stack_pop),
    .o_fwrite(o_fwrite)
  );

  ////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    // File array resets to one byte; the carry chain makes entries diverge
    for (int k = 0; k < NUM_FILES; k++)
      mem[k] = FILE_RST;
    {acc, opt, car, pc} = {ACC_RST, OPTION_RST, CARRY_RST, PC_RST};
    {we, fa} = '0;
    repeat (2) @(negedge i_clk);
    chk(o_pc, pc);
    chk(o_instr_ready, 16'h1);
    i_rst_n = 1;
    for (int n = 0; n < 300; n++)
    begin
      rs = lfsr(rs);
      {sel, f} = {rs[7:5], rs[4:0]};
      i_ce = !(sel == 7 && rs[0]);
      // A frozen cycle keeps the last write pulse standing on the port
      if (i_ce)
        we = 0;
      case (sel)
        0, 1:
        begin
          w = ENC_OPTION_LOAD;
          opt = acc;
        end
        2:
        begin
          acc = lfsr(rs);
          pc = {rs[0], acc};
          i_top_stack_entry = pc;
          w = {OPC_RETURN_LIT, acc};
        end
        // Unknown word and a disabled cycle both leave state alone
        7: w = rs[0] ? {OPC_ROTATE_LEFT, 1'b0, f} : 12'h000;
        default:
        begin
          w = {OPC_ROTATE_LEFT, sel > 4, f};
          v = mem[f];
          r = {v[6:0], car};
          car = v[7];
          we = sel > 4;
          fa = f;
          if (we)
            mem[f] = r;
          else
            acc = r;
        end
      endcase
      i_instr = {1'b1, w};
      @(negedge i_clk);
      if (sel == 2)
      begin
        chk(o_stack_pop, 16'h1);
        chk(o_pc, pc);
        chk(o_instr_ready, 16'h0);
        // Offered while not ready: must be dropped
        i_instr = {1'b1, ENC_OPTION_LOAD};
        @(negedge i_clk);
        chk(o_pc_load, 16'h1);
      end
      chk(o_acc, acc);
      chk(o_option, opt);
      chk(o_carry, car);
      chk(o_fwrite.we, we);
      if (we)
        chk(o_fwrite, {we, fa, r});
    end
    summarize();
  end
endmodule // baseline_instr_exec_subset_test
